// File: pkg/hfit_cfg.svh
/*
  Constants for the host buffer, interrupt and timer block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 25 MHz system clock and APB byte addresses on a 12-bit bus.
*/
// Overview of operation
// - One store of 64 bytes between host and command logic.
// - Data port write pushes a byte; read returns oldest byte and advances.
// - Fill register shows stored byte count in seven bits.
// - The same store serves host and command logic in both directions.
// - Flush bit empties the store and clears the overflow error.
// - Overflow error stays set until a flush.
// - Almost full when free space is at most the water mark.
// - Almost empty when stored count is at most the water mark.
// - Alert rising with its enable set raises the interrupt pin.
// - Events set their flag bits; enabled flags raise the pin and the global interrupt status bit.
// - Transmit done flag set when data ends and frame end begins.
// - Checksum done flag set when checksum ready goes high.
// - Receive done flag set at end of received data.
// - Command done flag set when command code returns to idle.
// - Alert interrupt flags set when their alert flags become one.
// - Error interrupt flag set while any error bit is one during activity.
// - Timer runs from 13.56 MHz through a 12-bit reloadable prescaler.
// - Second stage is a 16-bit reloadable counter readable by host.
// - Prescale period is twice value plus one, or plus two if even.
// - Count 1 to 0 sets timer flag; then halt or reload.
// - Start, stop and auto start bits control timer; running bit shown.
// - A byte arriving when full is dropped and sets overflow.
`ifndef HFIT_CFG_SVH
`define HFIT_CFG_SVH

`define OFF_COMMAND 12'h000
`define OFF_IRQ_ENABLE 12'h004
`define OFF_COMMON_IRQ 12'h008
`define OFF_ERROR_FLAGS 12'h00C
`define OFF_PRIMARY_STATUS 12'h010
`define OFF_BUFFER_DATA_PORT 12'h014
`define OFF_BUFFER_FILL 12'h018
`define OFF_WATER_MARK 12'h01C
`define OFF_MISC_CONTROL 12'h020
`define OFF_TIMER_MODE 12'h024
`define OFF_PRESCALE_LOW 12'h028
`define OFF_COUNT_RELOAD 12'h02C
`define OFF_COUNT_VALUE 12'h030

`define IRQ_TIMER 0
`define IRQ_ERR 1
`define IRQ_ALMOST_EMPTY 2
`define IRQ_ALMOST_FULL 3
`define IRQ_CMD_DONE 4
`define IRQ_RX 5
`define IRQ_TX 6
`define IRQ_CHECKSUM 7
`define IRQ_SET_BIT 8

`define ERR_OVF_BIT 4
`define ST_ALMOST_EMPTY 0
`define ST_ALMOST_FULL 1
`define ST_TIMER_RUNNING 3
`define ST_IRQ 4
`define ST_CHECKSUM_READY 5
`define FLUSH_BIT 7
`define CTRL_STOP_BIT 7
`define CTRL_START_BIT 6
`define MODE_AUTO_BIT 7
`define MODE_RESTART_BIT 5
`define MODE_EVEN_BIT 4

`define CMD_IDLE 4'h0
`define WATER_MARK_RST 6'h08
`define SYS_KHZ 25000
`define TIMER_IN_KHZ 13560

`endif

// File: pkg/hfit_pkg.sv
/*
  Shared types for the host buffer, interrupt and timer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package hfit_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] cmd_t;
  typedef enum logic {TMR_IDLE, TMR_RUN} tmr_state_e;
endpackage
`default_nettype wire

// File: pkg/fifo_if.sv
/*
  Interface between the register block and the byte store.
  Assumes one clock; the controller side drives requests.
*/
`default_nettype none
interface fifo_if #(parameter int W = 8, parameter int AW = 7);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [AW-1:0] count;
  logic drop;
  modport ctrl(output push, pop, flush, wdata, input rdata, count, drop);
  modport store(input push, pop, flush, wdata, output rdata, count, drop);
endinterface
`default_nettype wire

// File: rtl/byte_fifo.sv
/*
  Flip-flop byte store with flush and drop report.
  Assumes DEPTH is a power of two and AW holds DEPTH itself.
*/
`default_nettype none
module byte_fifo #(parameter int W = 8, parameter int DEPTH = 64, parameter int AW = 7) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  fifo_if.store f
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-2:0] wp_q;
  logic [AW-2:0] rp_q;
  logic [AW-1:0] cnt_q;
  wire full = (cnt_q == AW'(DEPTH));
  wire empty = (cnt_q == '0);
  wire do_push = f.push & ~full & ~f.flush;
  wire do_pop = f.pop & ~empty & ~f.flush;

  assign f.rdata = mem_q[rp_q];
  assign f.count = cnt_q;
  // Flush and a full push together: byte is lost to the flush, not an overflow
  assign f.drop = f.push & full & ~f.flush;

  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (ce && f.flush)) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
      if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // byte_fifo
`default_nettype wire

// File: rtl/prescale_timer.sv
/*
  Two-stage timer: 13.56 MHz tick from the system clock, prescaler, counter.
  Assumes the system clock rate in the config header.
*/
`default_nettype none
`include "hfit_cfg.svh"
module prescale_timer #(parameter int PW = 12, parameter int CW = 16) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic stop,
  input wire logic restart,
  input wire logic even,
  input wire logic [PW-1:0] presc,
  input wire logic [CW-1:0] reload,
  output logic running,
  output logic [CW-1:0] value,
  output logic expired
);
  import hfit_pkg::*;
  tmr_state_e st_q;
  logic [15:0] acc_q;
  logic [PW:0] pre_q;
  // Fractional accumulator: jitter of one system clock on each timer tick
  wire [16:0] acc_sum = {1'b0, acc_q} + 17'(`TIMER_IN_KHZ);
  wire tick = (acc_sum >= 17'(`SYS_KHZ));
  wire [PW:0] period_m1 = {presc, even};

  assign running = (st_q == TMR_RUN);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
    end else if (ce) begin
      acc_q <= tick ? 16'(acc_sum - 17'(`SYS_KHZ)) : acc_sum[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= TMR_IDLE;
      pre_q <= '0;
      value <= '0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (stop) begin
        st_q <= TMR_IDLE;
      end else if (start) begin
        st_q <= TMR_RUN;
        pre_q <= period_m1;
        value <= reload;
      end else if (running && tick) begin
        if (pre_q != '0) begin
          pre_q <= pre_q - 1'b1;
        end else begin
          pre_q <= period_m1;
          if (value != '0) begin
            value <= value - 1'b1;
            expired <= (value == CW'(1));
          end else if (restart) begin
            value <= reload;
          end else begin
            st_q <= TMR_IDLE;
          end
        end
      end
    end
  end
endmodule // prescale_timer
`default_nettype wire

// File: rtl/host_fifo_irq_timer.sv
/*
  Host register block: APB slave, shared byte store, alerts, interrupt
  flags and pin, and the two-stage timer.
  Assumes a 25 MHz clock, a synchronous active-high reset and that the
  command logic pulses its event inputs for one clock each.
*/
`default_nettype none
`include "hfit_cfg.svh"
module host_fifo_irq_timer #(
  parameter int DEPTH = 64,
  parameter int AW = 7,
  parameter int WL_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sm_push,
  input wire hfit_pkg::byte_t sm_wdata,
  input wire logic sm_pop,
  output hfit_pkg::byte_t sm_rdata,
  output hfit_pkg::cmd_t command_code,
  input wire logic cmd_done,
  input wire logic tx_frame_end,
  input wire logic rx_data_end,
  input wire logic checksum_ready,
  input wire logic [7:0] err_bits,
  input wire logic timer_auto_event,
  output logic irq
);
  import hfit_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cmd_t cmd_q;
  logic [7:0] en_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [WL_W-1:0] wl_q;
  logic [7:0] mode_q;
  logic [7:0] presc_lo_q;
  logic [15:0] reload_q;
  logic ovf_q;
  logic ovf_d;
  logic ae_q;
  logic af_q;
  logic crc_q;
  logic irq_d;
  cmd_t cmd_d;

  fifo_if #(.W(8), .AW(AW)) fif ();

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // One wait state: the read value is taken in the first access cycle,
  // which keeps the read mux out of the prdata output path.
  wire acc = psel & penable;
  wire capture = acc & ~pready;
  wire commit = acc & pready;
  wire wr = commit & pwrite;

  wire sel_cmd = (paddr == `OFF_COMMAND);
  wire sel_en = (paddr == `OFF_IRQ_ENABLE);
  wire sel_flags = (paddr == `OFF_COMMON_IRQ);
  wire sel_err = (paddr == `OFF_ERROR_FLAGS);
  wire sel_status = (paddr == `OFF_PRIMARY_STATUS);
  wire sel_data = (paddr == `OFF_BUFFER_DATA_PORT);
  wire sel_fill = (paddr == `OFF_BUFFER_FILL);
  wire sel_wl = (paddr == `OFF_WATER_MARK);
  wire sel_ctrl = (paddr == `OFF_MISC_CONTROL);
  wire sel_mode = (paddr == `OFF_TIMER_MODE);
  wire sel_plo = (paddr == `OFF_PRESCALE_LOW);
  wire sel_rld = (paddr == `OFF_COUNT_RELOAD);
  wire sel_val = (paddr == `OFF_COUNT_VALUE);
  wire hit = sel_cmd | sel_en | sel_flags | sel_err | sel_status | sel_data |
             sel_fill | sel_wl | sel_ctrl | sel_mode | sel_plo | sel_rld | sel_val;

  // ----------------------------------------------------------------------
  // Byte store
  // ----------------------------------------------------------------------
  wire fifo_empty = (fif.count == '0);
  // Host read pops at the capture edge so the byte is already in prdata
  wire host_pop = capture & ~pwrite & sel_data & hit;
  wire host_push = wr & sel_data;
  wire host_flush = wr & sel_fill & pwdata[`FLUSH_BIT];
  // Command logic has priority; a clashing host byte is lost
  assign fif.push = sm_push | host_push;
  assign fif.pop = sm_pop | host_pop;
  assign fif.wdata = sm_push ? sm_wdata : pwdata[7:0];
  assign fif.flush = host_flush;

  byte_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .f(fif)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      sm_rdata <= '0;
    end else if (ce && sm_pop && !fifo_empty) begin
      sm_rdata <= fif.rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Overflow and alerts
  // ----------------------------------------------------------------------
  // Drop beats flush in the same cycle only if the flush did not take it
  assign ovf_d = fif.drop ? 1'b1 : (host_flush ? 1'b0 : ovf_q);

  wire [AW-1:0] free_cnt = AW'(DEPTH) - fif.count;
  wire [AW-1:0] wl_ext = AW'(wl_q);
  wire almost_full = (free_cnt <= wl_ext);
  wire almost_empty = (fif.count <= wl_ext);
  wire af_rise = almost_full & ~af_q;
  wire ae_rise = almost_empty & ~ae_q;
  wire crc_rise = checksum_ready & ~crc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
      // Store is empty and under the reset water mark: no false alert edge
      ae_q <= 1'b1;
      af_q <= 1'b0;
      crc_q <= 1'b0;
    end else if (ce) begin
      ovf_q <= ovf_d;
      ae_q <= almost_empty;
      af_q <= almost_full;
      crc_q <= checksum_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Command code
  // ----------------------------------------------------------------------
  // A host write wins over a completion in the same cycle: new command
  wire cmd_busy = (cmd_q != `CMD_IDLE);
  assign cmd_d = (wr && sel_cmd) ? pwdata[3:0] : (cmd_done ? `CMD_IDLE : cmd_q);
  wire cmd_to_idle = cmd_busy & (cmd_d == `CMD_IDLE);

  // ----------------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------------
  wire tmr_running;
  wire [15:0] tmr_value;
  wire tmr_expired;
  wire tmr_start = (wr & sel_ctrl & pwdata[`CTRL_START_BIT]) |
                   (mode_q[`MODE_AUTO_BIT] & timer_auto_event);
  wire tmr_stop = wr & sel_ctrl & pwdata[`CTRL_STOP_BIT];

  prescale_timer #(.PW(12), .CW(16)) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(tmr_start),
    .stop(tmr_stop),
    .restart(mode_q[`MODE_RESTART_BIT]),
    .even(mode_q[`MODE_EVEN_BIT]),
    .presc({mode_q[3:0], presc_lo_q}),
    .reload(reload_q),
    .running(tmr_running),
    .value(tmr_value),
    .expired(tmr_expired)
  );

  // ----------------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------------
  wire [7:0] err_all = err_bits | (8'(ovf_q) << `ERR_OVF_BIT);
  // Error flag is level driven only while a command is active
  wire err_ev = (|err_all) & cmd_busy;

  wire [7:0] ev;
  assign ev[`IRQ_TIMER] = tmr_expired;
  assign ev[`IRQ_ERR] = err_ev;
  assign ev[`IRQ_ALMOST_EMPTY] = ae_rise;
  assign ev[`IRQ_ALMOST_FULL] = af_rise;
  assign ev[`IRQ_CMD_DONE] = cmd_to_idle;
  assign ev[`IRQ_RX] = rx_data_end;
  assign ev[`IRQ_TX] = tx_frame_end;
  assign ev[`IRQ_CHECKSUM] = crc_rise;

  wire flags_wr = wr & sel_flags;
  wire flags_set_mode = pwdata[`IRQ_SET_BIT];
  wire [7:0] sw_set = (flags_wr && flags_set_mode) ? pwdata[7:0] : 8'h00;
  wire [7:0] sw_clr = (flags_wr && !flags_set_mode) ? pwdata[7:0] : 8'h00;
  // Hardware set wins over a software clear in the same cycle
  assign flags_d = (flags_q & ~sw_clr) | sw_set | ev;
  assign irq_d = |(flags_d & en_q);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= `CMD_IDLE;
      en_q <= 8'h00;
      flags_q <= 8'h00;
      irq <= 1'b0;
    end else if (ce) begin
      cmd_q <= cmd_d;
      flags_q <= flags_d;
      irq <= irq_d;
      if (wr && sel_en) en_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wl_q <= `WATER_MARK_RST;
      mode_q <= 8'h00;
      presc_lo_q <= 8'h00;
      reload_q <= 16'h0000;
    end else if (ce) begin
      if (wr && sel_wl) wl_q <= pwdata[WL_W-1:0];
      if (wr && sel_mode) mode_q <= pwdata[7:0];
      if (wr && sel_plo) presc_lo_q <= pwdata[7:0];
      if (wr && sel_rld) reload_q <= pwdata[15:0];
    end
  end

  assign command_code = cmd_q;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [7:0] status_v = (8'(almost_empty) << `ST_ALMOST_EMPTY) |
                        (8'(almost_full) << `ST_ALMOST_FULL) |
                        (8'(tmr_running) << `ST_TIMER_RUNNING) |
                        (8'(irq) << `ST_IRQ) |
                        (8'(checksum_ready) << `ST_CHECKSUM_READY);
  // Empty store reads as zero and leaves the pointers alone
  wire [7:0] data_v = fifo_empty ? 8'h00 : fif.rdata;
  wire [31:0] rd_mux =
    sel_cmd ? 32'(cmd_q) :
    sel_en ? 32'(en_q) :
    sel_flags ? 32'(flags_q) :
    sel_err ? 32'(err_all) :
    sel_status ? 32'(status_v) :
    sel_data ? 32'(data_v) :
    sel_fill ? 32'(fif.count) :
    sel_wl ? 32'(wl_q) :
    sel_mode ? 32'(mode_q) :
    sel_plo ? 32'(presc_lo_q) :
    sel_rld ? 32'(reload_q) :
    sel_val ? 32'(tmr_value) :
    32'h0000_0000;

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= capture;
      pslverr <= capture & ~hit;
      if (capture) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

endmodule // host_fifo_irq_timer
`default_nettype wire

// File: testbench/host_fifo_irq_timer_sva.sv
/*
  Checker for the bus timing and command field of the block.
  Assumes it is bound to the top module; handshake checks weigh ce.
*/
`default_nettype none
`include "hfit_cfg.svh"
module hfit_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire hfit_pkg::cmd_t command_code,
  input wire logic cmd_done,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import hfit_pkg::*;
  logic cmd_wr;
  assign cmd_wr = psel && penable && pready && pwrite && paddr == `OFF_COMMAND;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------
  // Sequences
  // ----------
  sequence s_access;
    psel && penable && !pready && ce;
  endsequence
  sequence s_done;
    cmd_done && ce && command_code != `CMD_IDLE && !cmd_wr;
  endsequence
  // ----------
  // Properties
  // ----------
  AST_ACCESS_WAIT: assert property (s_access |=> pready)
    else $error("pready missing after access cycle");
  AST_READY_PULSE: assert property (pready && ce |=> !pready)
    else $error("pready held longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without a request");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside a completion");
  AST_ERR_DATA_ZERO: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  AST_WRITE_DATA_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  AST_CMD_IDLE: assert property (s_done |=> command_code == `CMD_IDLE)
    else $error("command field not idle after done");
  AST_CMD_WRITE: assert property (cmd_wr && ce |=> command_code == $past(pwdata[3:0]))
    else $error("command write not taken");
  AST_RESET_QUIET: assert property ($fell(rst) |-> !pready && !irq && command_code == 4'h0)
    else $error("outputs not clear after reset");
endmodule // hfit_chk
bind host_fifo_irq_timer hfit_chk chk_i (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .command_code(command_code), .cmd_done(cmd_done),
  .irq(irq));
`default_nettype wire

// File: testbench/host_model.sv
/*
  Host controller model: an APB master issuing one transfer at a time.
  Assumes tasks are entered just after a rising clock edge.
*/
`default_nettype none
module host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err_q;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_q = 1'b0;
  end
  // Strictly serial, so the data port is never hit behind a command
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No limit here: only the bench watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule // host_model
`default_nettype wire

// File: testbench/tb_host_fifo_irq_timer.sv
/*
  Self-checking bench: buffer, alerts, event flags, timer and bus refusal.
  Assumes the host model as APB master; ce drops only in the hold scenario.
*/
`default_nettype none
`include "hfit_cfg.svh"
module tb_host_fifo_irq_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import hfit_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic sm_push, sm_pop, cmd_done, tx_frame_end, rx_data_end, checksum_ready, auto_ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  byte_t sm_wdata, sm_rdata;
  cmd_t command_code;
  logic [7:0] err_bits;
  logic ce;
  int n_mismatch = 0;
  int cmp_count = 0;
  host_model hm (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  host_fifo_irq_timer uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sm_push(sm_push), .sm_wdata(sm_wdata), .sm_pop(sm_pop),
    .sm_rdata(sm_rdata), .command_code(command_code), .cmd_done(cmd_done),
    .tx_frame_end(tx_frame_end), .rx_data_end(rx_data_end), .checksum_ready(checksum_ready),
    .err_bits(err_bits), .timer_auto_event(auto_ev), .irq(irq));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    hm.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    hm.xfer(1'b1, a, d, q);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_fifo();
    logic [31:0] q;
    rd(`OFF_WATER_MARK, q); chk("water mark", q, 32'h8);
    wr(`OFF_IRQ_ENABLE, 32'h08);
    for (int i = 0; i < 65; i++) wr(`OFF_BUFFER_DATA_PORT, i);
    rd(`OFF_BUFFER_FILL, q); chk("fill", q, 32'd64);
    rd(`OFF_ERROR_FLAGS, q); chk("overflow", q[4], 1'b1);
    rd(`OFF_PRIMARY_STATUS, q); chk("alerts", q[1:0], 2'b10);
    chk("irq full", irq, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(`OFF_BUFFER_DATA_PORT, q); chk("pop", q, i);
    end
    wr(`OFF_BUFFER_FILL, 32'h00);
    rd(`OFF_ERROR_FLAGS, q); chk("overflow held", q[4], 1'b1);
    wr(`OFF_BUFFER_FILL, 32'h80);
    rd(`OFF_BUFFER_FILL, q); chk("flushed", q, 32'h0);
    rd(`OFF_ERROR_FLAGS, q); chk("overflow clr", q[4], 1'b0);
    rd(`OFF_COMMON_IRQ, q); chk("alert flags", q[3:2], 2'b11);
    wr(`OFF_COMMON_IRQ, 32'hFF);
    $display("done fifo");
  endtask
  task automatic t_shared();
    logic [31:0] q;
    byte_t ex[2] = '{8'h5A, 8'h3C};
    sm_wdata <= 8'hA5; sm_push <= 1'b1; @(posedge clk);
    sm_wdata <= 8'h5A; @(posedge clk);
    sm_push <= 1'b0;
    rd(`OFF_BUFFER_DATA_PORT, q); chk("host pop", q, 32'hA5);
    wr(`OFF_BUFFER_DATA_PORT, 32'h3C);
    for (int i = 0; i < 2; i++) begin
      sm_pop <= 1'b1; @(posedge clk);
      sm_pop <= 1'b0; @(posedge clk);
      chk("sm pop", sm_rdata, ex[i]);
    end
    $display("done shared");
  endtask
  task automatic t_events();
    logic [31:0] q;
    wr(`OFF_IRQ_ENABLE, 32'hF2);
    wr(`OFF_COMMAND, 32'h1);
    err_bits <= 8'h01; tx_frame_end <= 1'b1; rx_data_end <= 1'b1;
    cmd_done <= 1'b1; checksum_ready <= 1'b1; @(posedge clk);
    err_bits <= 8'h00; tx_frame_end <= 1'b0; rx_data_end <= 1'b0; cmd_done <= 1'b0;
    @(posedge clk);
    chk("cmd idle", command_code, 4'h0);
    rd(`OFF_COMMON_IRQ, q); chk("evt flags", {q[7:4], q[1]}, 5'h1F);
    rd(`OFF_PRIMARY_STATUS, q); chk("irq status", q[5:4], 2'b11);
    chk("irq pin", irq, 1'b1);
    wr(`OFF_COMMON_IRQ, 32'hFF);
    chk("irq cleared", irq, 1'b0);
    checksum_ready <= 1'b0;
    $display("done events");
  endtask
  task automatic t_timer();
    logic [31:0] q;
    int n, ex;
    wr(`OFF_PRESCALE_LOW, 32'h2);
    wr(`OFF_COUNT_RELOAD, 32'd20);
    wr(`OFF_IRQ_ENABLE, 32'h01);
    for (int e = 0; e < 2; e++) begin
      wr(`OFF_TIMER_MODE, e << `MODE_EVEN_BIT);
      wr(`OFF_COMMON_IRQ, 32'hFF);
      wr(`OFF_MISC_CONTROL, 32'h40);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      ex = 20 * (5 + e) * `SYS_KHZ / `TIMER_IN_KHZ;
      chk("delay", n > ex - 6 && n < ex + 6, 1'b1);
      // Halt comes one prescale period after the count reaches zero
      repeat (16) @(posedge clk);
      rd(`OFF_PRIMARY_STATUS, q); chk("halted", q[3], 1'b0);
      rd(`OFF_COUNT_VALUE, q); chk("count", q, 32'h0);
    end
    wr(`OFF_TIMER_MODE, 32'hA0);
    auto_ev <= 1'b1; @(posedge clk);
    auto_ev <= 1'b0;
    rd(`OFF_PRIMARY_STATUS, q); chk("auto run", q[3], 1'b1);
    wr(`OFF_COMMON_IRQ, 32'hFF);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (16) @(posedge clk);
    rd(`OFF_PRIMARY_STATUS, q);
    chk("reloaded", {irq, q[3]}, 2'b11);
    wr(`OFF_MISC_CONTROL, 32'hC0);
    rd(`OFF_PRIMARY_STATUS, q); chk("stopped", q[3], 1'b0);
    wr(`OFF_COMMON_IRQ, 32'h101);
    rd(`OFF_COMMON_IRQ, q); chk("host set", q[0], 1'b1);
    $display("done timer");
  endtask
  task automatic t_hold();
    logic [31:0] q;
    ce <= 1'b0;
    sm_wdata <= 8'h11;
    sm_push <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    sm_push <= 1'b0;
    rd(`OFF_BUFFER_FILL, q);
    chk("frozen fill", q, 32'h0);
    wr(`OFF_WATER_MARK, 32'h20);
    wr(`OFF_BUFFER_DATA_PORT, 32'h77);
    rd(`OFF_BUFFER_FILL, q);
    chk("fill one", q, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("irq reset", irq, 1'b0);
    rd(`OFF_WATER_MARK, q);
    chk("wl reset", q, 32'h8);
    rd(`OFF_BUFFER_FILL, q);
    chk("fill reset", q, 32'h0);
    $display("done hold");
  endtask
  task automatic t_refuse();
    logic [31:0] q;
    rd(12'hFFC, q);
    chk("unmapped data", q, 32'h0);
    chk("unmapped err", hm.err_q, 1'b1);
    $display("done refuse");
  endtask
  // ----------
  // Run
  // ----------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {sm_push, sm_pop, cmd_done, tx_frame_end, rx_data_end, checksum_ready, auto_ev} = '0;
    sm_wdata = 8'h00;
    err_bits = 8'h00;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_fifo();
    t_shared();
    t_events();
    t_timer();
    t_hold();
    t_refuse();
    conclude();
  end
endmodule // tb_host_fifo_irq_timer
`default_nettype wire
